/* File: rtl/tmw_pkg.sv */
// Package with register map, field positions and mode codes of the 8-bit timer
package tmw_pkg;
    localparam int           CNT_W         = 8;
    localparam logic [7:0]   CNT_MAX       = 8'hff;
    localparam logic [7:0]   CNT_BOTTOM    = 8'h00;
    // Register byte offsets
    localparam logic [7:0]   OFS_CTRL_A    = 8'h00;
    localparam logic [7:0]   OFS_CTRL_B    = 8'h04;
    localparam logic [7:0]   OFS_COUNTER   = 8'h08;
    localparam logic [7:0]   OFS_CMP_A     = 8'h0c;
    localparam logic [7:0]   OFS_CMP_B     = 8'h10;
    localparam logic [7:0]   OFS_FLAGS     = 8'h14;
    // Control A fields
    localparam int           CA_MODE_A_LSB = 6;
    localparam int           CA_MODE_B_LSB = 4;
    localparam int           CA_WGM_LSB    = 0;
    // Control B fields
    localparam int           CB_RUN_BIT    = 0;
    localparam int           CB_WGM_HI_BIT = 3;
    localparam int           CB_FORCE_B    = 6;
    localparam int           CB_FORCE_A    = 7;
    // Flag fields
    localparam int           FL_OVF_BIT    = 0;
    localparam int           FL_CMP_A_BIT  = 1;
    localparam int           FL_CMP_B_BIT  = 2;
    // Reset values
    localparam logic [7:0]   RST_BYTE      = 8'h00;
    localparam logic [1:0]   RST_COM       = 2'h0;
    localparam logic [2:0]   RST_WGM       = 3'h0;
    // Waveform generation modes
    typedef enum logic [2:0] {
        WGM_NORMAL   = 3'b000,
        WGM_CLEAR    = 3'b010,
        WGM_FAST     = 3'b011,
        WGM_FAST_TOP = 3'b111
    } tmw_wgm_type;
    // Compare output modes
    localparam logic [1:0]   COM_OFF       = 2'h0;
    localparam logic [1:0]   COM_TOGGLE    = 2'h1;
    localparam logic [1:0]   COM_CLEAR     = 2'h2;
    localparam logic [1:0]   COM_SET       = 2'h3;
endpackage

/* File: rtl/tmw_timer.sv */
// Top module: 8-bit timer with compare outputs, normal, clear-on-match and fast PWM modes
//
// Overview of operation
// RL1 - Output mode field picks next waveform state and selects waveform or port for pin.
// RL2 - Reset clears both internal waveform output registers to zero.
// RL3 - Nonzero output mode field routes waveform instead of port value; direction unchanged.
// RL4 - Software must set the pin direction to output to see the waveform.
// RL5 - Output mode zero leaves the waveform state unchanged on a match.
// RL6 - New output mode acts at next match; force strobe acts at once in non-PWM.
// RL7 - Count sequence depends only on generation mode, never on output mode fields.
// RL8 - Mode 0 counts up always, wrapping 0xFF to 0x00, no compare clear.
// RL9 - Normal mode sets overflow flag as counter becomes zero; interrupt completion or a flag write clears it.
// RL10 - Overflow flag clears automatically when its interrupt is executed.
// RL11 - Mode 2 clears the counter when it equals compare value A.
// RL12 - Clear-on-match compare A unbuffered; below count means wrap through 0xFF first.
// RL13 - Clear-on-match sets compare flag A each time the counter reaches top.
// RL14 - Clear-on-match with output mode 1 toggles channel A on every match.
// RL15 - Clear-on-match sets overflow flag when counter rolls from maximum to zero.
// RL16 - Modes 3 and 7 count single slope to top: 0xFF or compare value A.
// RL17 - Fast PWM mode 2 clears on match, sets at zero; mode 3 inverse.
// RL18 - Fast PWM counts until equal to top, then clears next timer cycle.
// RL19 - Fast PWM sets overflow flag each time the counter reaches top.
// RL20 - Fast PWM output mode 1 toggles A only with mode high bit; never B.
// RL21 - Fast PWM compare zero gives one-tick spike; maximum gives constant output level.
// RL22 - Fast PWM keeps compare writes double buffered, toggle option included.
// RL23 - PWM modes load buffered compare values into active registers only at top.
// RL24 - Forced compare updates output only; no flag, no counter clear or reload.
// RL25 - Compare flag sets on timer cycle after counter equals the compare value.
// RL26 - Software counter write blocks every match in the next timer cycle.
// RL27 - All logic on one system clock, advancing only on timer clock enable.
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module tmw_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_tick,
    input  wire logic        ovf_irq_done,
    input  wire logic        cmp_a_irq_done,
    input  wire logic        cmp_b_irq_done,
    input  wire logic [1:0]  port_out_value,
    input  wire logic [1:0]  port_dir,
    output logic      [1:0]  pin_out,
    output logic      [1:0]  pin_oe,
    output logic      [1:0]  waveform_output,
    output logic      [2:0]  flags_out
);

    // Control and data registers
    logic [1:0]  compare_output_mode_field [2];
    logic [2:0]  waveform_generation_mode_field;
    logic        run_r;
    logic [7:0]  counter_value_r;
    logic [7:0]  counter_value_nxt;
    logic [7:0]  cmp_buf_r [2];
    logic [7:0]  cmp_act_r [2];
    logic        block_r;
    logic        overflow_flag_r;
    logic [1:0]  channel_compare_flag_r;
    logic [1:0]  wave_r;
    logic [31:0] prdata_r;

    // Bus decode
    wire         setup_ph    = psel & ~penable;
    wire         access_ph   = psel & penable;
    wire         wr_en       = access_ph & pwrite;
    wire         sel_ctrl_a  = (paddr == tmw_pkg::OFS_CTRL_A);
    wire         sel_ctrl_b  = (paddr == tmw_pkg::OFS_CTRL_B);
    wire         sel_counter = (paddr == tmw_pkg::OFS_COUNTER);
    wire         sel_cmp_a   = (paddr == tmw_pkg::OFS_CMP_A);
    wire         sel_cmp_b   = (paddr == tmw_pkg::OFS_CMP_B);
    wire         sel_flags   = (paddr == tmw_pkg::OFS_FLAGS);
    wire         mapped      = sel_ctrl_a | sel_ctrl_b | sel_counter
                               | sel_cmp_a | sel_cmp_b | sel_flags;
    wire         wr_ctrl_a   = wr_en & sel_ctrl_a;
    wire         wr_ctrl_b   = wr_en & sel_ctrl_b;
    wire         wr_counter  = wr_en & sel_counter;
    wire         wr_flags    = wr_en & sel_flags;
    wire [1:0]   wr_cmp      = {wr_en & sel_cmp_b, wr_en & sel_cmp_a};

    assign pready  = penable;
    assign pslverr = access_ph & ~mapped;
    assign prdata  = prdata_r;

    // Mode decode
    // RL7 count mode
    wire         mode_normal = (waveform_generation_mode_field == tmw_pkg::WGM_NORMAL);
    wire         mode_clear  = (waveform_generation_mode_field == tmw_pkg::WGM_CLEAR);
    wire         mode_fast   = (waveform_generation_mode_field == tmw_pkg::WGM_FAST)
                               | (waveform_generation_mode_field == tmw_pkg::WGM_FAST_TOP);
    wire         mode_hi     = waveform_generation_mode_field[2];
    // RL27 timer advance
    wire         tick        = timer_tick & run_r;
    // RL16 top select
    wire         top_is_a    = mode_clear
                               | (waveform_generation_mode_field == tmw_pkg::WGM_FAST_TOP);
    wire [7:0]   top_value   = top_is_a ? cmp_act_r[0] : tmw_pkg::CNT_MAX;
    wire         at_top      = (counter_value_r == top_value);
    wire         at_max      = (counter_value_r == tmw_pkg::CNT_MAX);
    // RL11 restart at top
    wire         restart     = (mode_clear | mode_fast) & at_top;
    // RL26 match blocking
    wire [1:0]   match;
    wire [1:0]   force_pulse;

    // RL8 counter sequence
    always_comb begin
        counter_value_nxt = counter_value_r;
        if (wr_counter) begin
            counter_value_nxt = pwdata[7:0];
        end else if (tick) begin
            // RL18 clear after top
            if (restart) begin
                counter_value_nxt = tmw_pkg::CNT_BOTTOM;
            end else begin
                counter_value_nxt = counter_value_r + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_value_r <= tmw_pkg::RST_BYTE;
        end else begin
            counter_value_r <= counter_value_nxt;
        end
    end

    // RL26 block after write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_r <= 1'b0;
        end else if (wr_counter) begin
            block_r <= 1'b1;
        end else if (tick) begin
            block_r <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_output_mode_field[0]        <= tmw_pkg::RST_COM;
            compare_output_mode_field[1]        <= tmw_pkg::RST_COM;
            waveform_generation_mode_field      <= tmw_pkg::RST_WGM;
            run_r                               <= 1'b0;
        end else begin
            if (wr_ctrl_a) begin
                compare_output_mode_field[0]       <= pwdata[tmw_pkg::CA_MODE_A_LSB +: 2];
                compare_output_mode_field[1]       <= pwdata[tmw_pkg::CA_MODE_B_LSB +: 2];
                waveform_generation_mode_field[1:0] <= pwdata[tmw_pkg::CA_WGM_LSB +: 2];
            end
            if (wr_ctrl_b) begin
                waveform_generation_mode_field[2] <= pwdata[tmw_pkg::CB_WGM_HI_BIT];
                run_r                             <= pwdata[tmw_pkg::CB_RUN_BIT];
            end
        end
    end

    // RL6 immediate force
    // RL24 force strobe
    assign force_pulse = {2{wr_ctrl_b & ~mode_fast}}
                         & {pwdata[tmw_pkg::CB_FORCE_B], pwdata[tmw_pkg::CB_FORCE_A]};

    // RL9 overflow flag
    // Counter write wins over count, so no wrap and no flag then
    wire ovf_set = tick & ~wr_counter & ((mode_fast & at_top) | (~mode_fast & at_max));
    // RL15 rollover in clear-on-match also reaches here through at_max
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_r <= 1'b0;
        end else if (ovf_set) begin
            // RL19 set at top
            overflow_flag_r <= 1'b1;
        end else if (ovf_irq_done | (wr_flags & pwdata[tmw_pkg::FL_OVF_BIT])) begin
            // RL10 cleared by interrupt
            overflow_flag_r <= 1'b0;
        end
    end

    // Per channel compare, flag and waveform logic
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic       next_wave;
            logic       flag_clr;
            wire  [1:0] com      = compare_output_mode_field[ch];
            wire        eq_cmp   = (counter_value_r == cmp_act_r[ch]);
            // RL25 match at tick
            assign match[ch]     = tick & eq_cmp & ~block_r;
            // RL20 toggle only on A
            wire        fast_tog = (ch == 0) & mode_hi & (com == tmw_pkg::COM_TOGGLE);
            // RL21 match at top ignored
            wire        ign_top  = mode_fast & com[1] & (cmp_act_r[ch] == top_value);

            // RL5 waveform next state
            always_comb begin
                next_wave = wave_r[ch];
                if (mode_fast) begin
                    if (tick & restart & com[1]) begin
                        // RL17 bottom action
                        next_wave = ~com[0];
                    end else if (match[ch] & ~ign_top) begin
                        if (com[1]) begin
                            next_wave = com[0];
                        end else if (fast_tog) begin
                            next_wave = ~wave_r[ch];
                        end
                    end
                end else if (match[ch] | force_pulse[ch]) begin
                    // RL14 toggle, clear or set
                    case (com)
                        tmw_pkg::COM_TOGGLE: next_wave = ~wave_r[ch];
                        tmw_pkg::COM_CLEAR:  next_wave = 1'b0;
                        tmw_pkg::COM_SET:    next_wave = 1'b1;
                        default:             next_wave = wave_r[ch];
                    endcase
                end
            end

            // RL2 waveform reset
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    wave_r[ch] <= 1'b0;
                end else begin
                    wave_r[ch] <= next_wave;
                end
            end

            // RL13 compare flag
            assign flag_clr = (ch == 0) ? cmp_a_irq_done : cmp_b_irq_done;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    channel_compare_flag_r[ch] <= 1'b0;
                end else if (match[ch]) begin
                    channel_compare_flag_r[ch] <= 1'b1;
                end else if (flag_clr | (wr_flags & pwdata[tmw_pkg::FL_CMP_A_BIT + ch])) begin
                    channel_compare_flag_r[ch] <= 1'b0;
                end
            end

            // RL22 buffered compare
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cmp_buf_r[ch] <= tmw_pkg::RST_BYTE;
                    cmp_act_r[ch] <= tmw_pkg::RST_BYTE;
                end else begin
                    if (wr_cmp[ch]) begin
                        cmp_buf_r[ch] <= pwdata[7:0];
                    end
                    if (!mode_fast && wr_cmp[ch]) begin
                        // RL12 direct load
                        cmp_act_r[ch] <= pwdata[7:0];
                    end else if (!mode_fast) begin
                        cmp_act_r[ch] <= cmp_buf_r[ch];
                    end else if (tick && at_top) begin
                        // RL23 load at top
                        cmp_act_r[ch] <= cmp_buf_r[ch];
                    end
                end
            end

            // RL3 pin override
            assign pin_out[ch] = (com != tmw_pkg::COM_OFF) ? wave_r[ch] : port_out_value[ch];
            // RL4 direction from port
            assign pin_oe[ch]  = port_dir[ch];
        end
    endgenerate

    assign waveform_output = wave_r;
    assign flags_out       = {channel_compare_flag_r, overflow_flag_r};

    // Read data, latched in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata_r <= 32'h0000_0000;
            if (sel_ctrl_a) begin
                prdata_r[7:0] <= {compare_output_mode_field[0], compare_output_mode_field[1],
                                  2'h0, waveform_generation_mode_field[1:0]};
            end else if (sel_ctrl_b) begin
                prdata_r[7:0] <= {4'h0, waveform_generation_mode_field[2], 2'h0, run_r};
            end else if (sel_counter) begin
                prdata_r[7:0] <= counter_value_r;
            end else if (sel_cmp_a) begin
                prdata_r[7:0] <= cmp_buf_r[0];
            end else if (sel_cmp_b) begin
                prdata_r[7:0] <= cmp_buf_r[1];
            end else if (sel_flags) begin
                prdata_r[7:0] <= {5'h00, channel_compare_flag_r, overflow_flag_r};
            end
        end
    end

endmodule

`default_nettype wire

/* File: verification/tmw_load.sv */
// External load model on the two compare output pins
`timescale 1ns/10ps
`default_nettype none
module tmw_load (
    input  wire logic       pclk,
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe,
    output logic      [1:0] pin_level
);
    logic [1:0] last_r = 2'h0;
    // Remember the level each pin was last driven to
    always_ff @(posedge pclk) begin
        last_r <= (pin_oe & pin_out) | (~pin_oe & last_r);
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : ~last_r[i];
        end
    end
endmodule
`default_nettype wire

/* File: verification/tmw_timer_bench.sv */
// Self-checking bench of the timer
`timescale 1ns/10ps
`default_nettype none
module tmw_timer_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, timer_tick;
    logic        ovf_irq_done, cmp_a_irq_done, cmp_b_irq_done;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  port_out_value, port_dir, pin_out, pin_oe, waveform_output, pin_level;
    logic [2:0]  flags_out;
    logic        last_err;
    int          err_count = 0;
    int          comparisons = 0;
    tmw_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_tick(timer_tick), .ovf_irq_done(ovf_irq_done),
        .cmp_a_irq_done(cmp_a_irq_done), .cmp_b_irq_done(cmp_b_irq_done),
        .port_out_value(port_out_value), .port_dir(port_dir), .pin_out(pin_out),
        .pin_oe(pin_oe), .waveform_output(waveform_output), .flags_out(flags_out));
    tmw_load load (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));
    always #12.5 pclk = ~pclk;
    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        if (n == 20) begin
            err_count++;
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask
    task automatic tick(input int n);
        @(posedge pclk);
        timer_tick <= 1'b1;
        repeat (n) @(posedge pclk);
        timer_tick <= 1'b0;
        #1;
    endtask
    task automatic test_reset;
        check("wave", 32'(waveform_output), 32'h0);
        rd_check("ctrl_a", tmw_pkg::OFS_CTRL_A, 32'h0);
        check("mapped err", 32'(last_err), 32'h0);
        rd_check("unmapped", 8'h18, 32'h0);
        check("unmapped err", 32'(last_err), 32'h1);
        $display("reset test done");
    endtask
    task automatic test_normal;
        wr(tmw_pkg::OFS_CTRL_B, 32'h01);
        wr(tmw_pkg::OFS_COUNTER, 32'hfe);
        tick(1);
        rd_check("count ff", tmw_pkg::OFS_COUNTER, 32'hff);
        check("ovf early", 32'(flags_out[0]), 32'h0);
        tick(1);
        rd_check("count wrap", tmw_pkg::OFS_COUNTER, 32'h0);
        check("ovf set", 32'(flags_out[0]), 32'h1);
        tick(3);
        check("ovf held", 32'(flags_out[0]), 32'h1);
        check("cmp flags", 32'(flags_out[2:1]), 32'h3);
        check("wave idle", 32'(waveform_output), 32'h0);
        @(posedge pclk);
        ovf_irq_done <= 1'b1;
        @(posedge pclk);
        ovf_irq_done <= 1'b0;
        #1;
        check("ovf irq clear", 32'(flags_out[0]), 32'h0);
        wr(tmw_pkg::OFS_FLAGS, 32'h07);
        check("flags cleared", 32'(flags_out), 32'h0);
        $display("normal test done");
    endtask
    task automatic test_clear_match;
        @(posedge pclk);
        port_dir <= 2'h3;
        port_out_value <= 2'h2;
        wr(tmw_pkg::OFS_CMP_A, 32'h03);
        wr(tmw_pkg::OFS_CTRL_A, 32'h42);
        wr(tmw_pkg::OFS_COUNTER, 32'h00);
        tick(3);
        check("toggle before", 32'(waveform_output[0]), 32'h0);
        tick(1);
        rd_check("match clear", tmw_pkg::OFS_COUNTER, 32'h0);
        check("cmp flag", 32'(flags_out[1]), 32'h1);
        check("blocked b", 32'(flags_out[2]), 32'h0);
        check("toggle", 32'(waveform_output[0]), 32'h1);
        check("pin a", 32'(pin_level), 32'h3);
        tick(4);
        check("period", 32'(waveform_output[0]), 32'h0);
        $display("clear on match test done");
    endtask
    task automatic test_force;
        wr(tmw_pkg::OFS_CTRL_A, 32'hc2);
        wr(tmw_pkg::OFS_FLAGS, 32'h07);
        wr(tmw_pkg::OFS_COUNTER, 32'h02);
        wr(tmw_pkg::OFS_CTRL_B, 32'h80);
        check("force set", 32'(waveform_output[0]), 32'h1);
        check("force flag", 32'(flags_out), 32'h0);
        rd_check("force count", tmw_pkg::OFS_COUNTER, 32'h02);
        wr(tmw_pkg::OFS_CTRL_A, 32'h82);
        wr(tmw_pkg::OFS_CTRL_B, 32'h80);
        check("force clear", 32'(waveform_output[0]), 32'h0);
        $display("force test done");
    endtask
    task automatic test_fast;
        wr(tmw_pkg::OFS_CMP_A, 32'h02);
        wr(tmw_pkg::OFS_CTRL_A, 32'h83);
        wr(tmw_pkg::OFS_CTRL_B, 32'h01);
        wr(tmw_pkg::OFS_COUNTER, 32'hfe);
        wr(tmw_pkg::OFS_FLAGS, 32'h07);
        tick(2);
        rd_check("top clear", tmw_pkg::OFS_COUNTER, 32'h0);
        check("pwm ovf", 32'(flags_out[0]), 32'h1);
        check("bottom set", 32'(waveform_output[0]), 32'h1);
        wr(tmw_pkg::OFS_CMP_A, 32'h05);
        tick(2);
        check("before match", 32'(waveform_output[0]), 32'h1);
        tick(1);
        check("buffered match", 32'(waveform_output[0]), 32'h0);
        wr(tmw_pkg::OFS_CTRL_A, 32'h53);
        wr(tmw_pkg::OFS_CTRL_B, 32'h09);
        wr(tmw_pkg::OFS_COUNTER, 32'h00);
        tick(3);
        rd_check("top a clear", tmw_pkg::OFS_COUNTER, 32'h0);
        check("toggle a", 32'(waveform_output[0]), 32'h1);
        tick(6);
        rd_check("new top", tmw_pkg::OFS_COUNTER, 32'h0);
        check("toggle a back", 32'(waveform_output[0]), 32'h0);
        check("no toggle b", 32'(waveform_output[1]), 32'h0);
        $display("fast pwm test done");
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, timer_tick} = 4'h0;
        {ovf_irq_done, cmp_a_irq_done, cmp_b_irq_done} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        port_out_value = 2'h0;
        port_dir = 2'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_normal();
        test_clear_match();
        test_force();
        test_fast();
        final_report();
    end
endmodule
`default_nettype wire

/* File: verification/tmw_timer_sva.sv */
// Checker of the timer port behaviour
`timescale 1ns/10ps
`default_nettype none
module tmw_timer_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        timer_tick,
    input wire logic        ovf_irq_done,
    input wire logic [1:0]  port_out_value,
    input wire logic [1:0]  port_dir,
    input wire logic [1:0]  pin_out,
    input wire logic [1:0]  pin_oe,
    input wire logic [1:0]  waveform_output,
    input wire logic [2:0]  flags_out
);
    logic [7:0] ctrl_a_r;
    wire        wr_en = psel && penable && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_r <= 8'h00;
        end else if (wr_en && paddr == tmw_pkg::OFS_CTRL_A) begin
            ctrl_a_r <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_oe_follows_dir: assert property (pin_oe == port_dir)
        else $error("pin enable differs from direction");
    a_reset_clears: assert property ($rose(presetn) |-> waveform_output == 2'h0)
        else $error("waveform not cleared by reset");
    a_pin_a_source: assert property (pin_out[0] ==
        (|ctrl_a_r[7:6] ? waveform_output[0] : port_out_value[0]))
        else $error("pin A source wrong");
    a_pin_b_source: assert property (pin_out[1] ==
        (|ctrl_a_r[5:4] ? waveform_output[1] : port_out_value[1]))
        else $error("pin B source wrong");
    a_ovf_clear_cause: assert property ($fell(flags_out[0]) |-> $past(ovf_irq_done) ||
        $past(wr_en && paddr == tmw_pkg::OFS_FLAGS && pwdata[0]))
        else $error("overflow flag cleared without cause");
    a_ovf_set_tick: assert property ($rose(flags_out[0]) |-> $past(timer_tick))
        else $error("overflow flag set without tick");
    a_cmp_set_tick: assert property ($rose(flags_out[1]) |-> $past(timer_tick))
        else $error("compare flag set without tick");
    a_wave_change_cause: assert property ($changed(waveform_output) |->
        $past(timer_tick) || $past(wr_en && paddr == tmw_pkg::OFS_CTRL_B))
        else $error("waveform changed without cause");
    c_ovf: cover property ($rose(flags_out[0]));
    c_cmp: cover property ($rose(flags_out[1]));
    c_wave: cover property ($changed(waveform_output[0]));
endmodule
bind tmw_timer tmw_timer_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .timer_tick(timer_tick), .ovf_irq_done(ovf_irq_done), .port_out_value(port_out_value),
    .port_dir(port_dir), .pin_out(pin_out), .pin_oe(pin_oe),
    .waveform_output(waveform_output), .flags_out(flags_out));
`default_nettype wire
